//--- mid_pkg.sv
// constants, encodings and types shared by the instruction decoder files
package mid_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int IW = 14;
	localparam int DW = 8;
	localparam int PCW = 12;
	localparam int FAW = 7;
	localparam int RAW = 6;

	// ----------------------------------------
	// register offsets and fields
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATE_OFS = 8'h04;
	localparam logic [7:0] PC_OFS = 8'h08;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_WAKE_BIT = 1;
	localparam int ST_ACC_LSB = 0;
	localparam int ST_C_BIT = 8;
	localparam int ST_NIB_BIT = 9;
	localparam int ST_Z_BIT = 10;
	localparam int ST_WDX_BIT = 11;
	localparam int ST_SLP_BIT = 12;
	localparam int ST_STBY_BIT = 13;
	localparam int ST_GIE_BIT = 14;
	localparam int ST_SKIP_BIT = 15;
	localparam int PC_SP_LSB = 16;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RUN_RST = 1'b1;
	localparam logic [DW-1:0] ACC_RST = 8'h00;
	localparam logic [PCW-1:0] PC_RST = 12'h000;
	localparam logic [IW-1:0] INSTR_RST = 14'h0000;
	localparam logic FLAG_RST = 1'b0;

	// ----------------------------------------
	// instruction encodings
	// ----------------------------------------
	localparam logic [IW-1:0] OPC_NOP = 14'h0000;
	localparam logic [IW-1:0] OPC_STANDBY = 14'h0003;
	localparam logic [IW-1:0] OPC_WDT_CLR = 14'h0004;
	localparam logic [IW-1:0] OPC_RETURN = 14'h0040;
	localparam logic [IW-1:0] OPC_RETURN_INT = 14'h0060;
	localparam logic [IW-1:0] OPC_ZERO_ACC = 14'h0140;
	localparam logic [1:0] PFX_BYTE = 2'h0;
	localparam logic [1:0] PFX_BIT = 2'h1;
	localparam logic [1:0] PFX_CALL = 2'h2;
	localparam logic [4:0] HI_ST_REG = 5'h01;
	localparam logic [4:0] HI_ZERO_REG = 5'h03;
	localparam logic [3:0] BY_SUB = 4'h2;
	localparam logic [3:0] BY_DEC = 4'h3;
	localparam logic [3:0] BY_OR = 4'h4;
	localparam logic [3:0] BY_AND = 4'h5;
	localparam logic [3:0] BY_XOR = 4'h6;
	localparam logic [3:0] BY_ADD = 4'h7;
	localparam logic [3:0] BY_MOVE = 4'h8;
	localparam logic [3:0] BY_INV = 4'h9;
	localparam logic [3:0] BY_INC = 4'ha;
	localparam logic [3:0] BY_DEC_SKIP = 4'hb;
	localparam logic [3:0] BY_ROT_R = 4'hc;
	localparam logic [3:0] BY_ROT_L = 4'hd;
	localparam logic [3:0] BY_SWAP = 4'he;
	localparam logic [3:0] BY_INC_SKIP = 4'hf;
	localparam logic [1:0] BIT_CLR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
	localparam logic [3:0] LIT_RETURN = 4'h8;
	localparam logic [3:0] LIT_LD = 4'h9;
	localparam logic [3:0] LIT_OR = 4'ha;
	localparam logic [3:0] LIT_AND = 4'hb;
	localparam logic [3:0] LIT_ADD = 4'hc;
	localparam logic [3:0] LIT_XOR = 4'hf;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_LOAD = 3'b001,
		ST_READ = 3'b010,
		ST_EXEC = 3'b011,
		ST_WAIT2 = 3'b100,
		ST_STANDBY = 3'b101
	} mid_state_t;

	typedef enum logic [5:0] {
		OP_NOP, OP_ST_RPL, OP_ST_REG, OP_ZERO_ACC, OP_ZERO_REG, OP_SUB, OP_DEC,
		OP_OR, OP_AND, OP_XOR, OP_ADD, OP_LD_REG, OP_TEST_NULL, OP_INV, OP_INC,
		OP_DEC_SKIP, OP_ROT_R, OP_ROT_L, OP_SWAP, OP_INC_SKIP, OP_BIT_CLR,
		OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET, OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT,
		OP_XOR_LIT, OP_LD_LIT, OP_RETURN_LIT, OP_CALL, OP_JUMP, OP_RETURN,
		OP_RETURN_INT, OP_STANDBY, OP_WDT_CLR
	} mid_op_t;

endpackage

//--- mid_rf_if.sv
// register file port between the decoder core and its data memory
`timescale 1ns/10ps
interface mid_rf_if #(parameter int AW = 7, parameter int DW = 8)
(
	input wire logic clk,
	input wire logic rst_n
);
	logic [AW-1:0] addr;
	logic we;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport core (output addr, output we, output wdata, input rdata);
	modport mem (input clk, input rst_n, input addr, input we, input wdata, output rdata);
endinterface

//--- mid_regfile.sv
// register file memory with registered read data
`timescale 1ns/10ps
module mid_regfile #(parameter int AW = 7, parameter int DW = 8)
(
	mid_rf_if.mem rf
);
	logic [DW-1:0] mem_reg [2**AW];
	logic [DW-1:0] rdata_reg;

	always_ff @(posedge rf.clk)
	begin
		if (rf.we)
		begin
			mem_reg[rf.addr] <= rf.wdata;
		end
	end

	always_ff @(posedge rf.clk)
	begin
		if (!rf.rst_n)
		begin
			rdata_reg <= '0;
		end
		else
		begin
			rdata_reg <= mem_reg[rf.addr];
		end
	end

	assign rf.rdata = rdata_reg;
endmodule

//--- mid_core.sv
// instruction decode and execute core with an AHB-Lite control slave
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Operation
// - fetch 14-bit words, split into operation code and operand fields
// - byte ops are 00, 4-bit code, destination bit, 7-bit address
// - destination bit 0 writes accumulator, 1 writes back to register
// - add, subtract, literal add update carry, nibble carry and zero
// - logic, invert, increment, decrement update only the zero flag
// - rotates go through carry only; nibble swap changes no flag
// - skip-on-zero ops write per destination, no flags, skip next if zero
// - bit clear and set touch one bit of addresses 00h to 3Fh
// - test-skip-clear skips next instruction when the bit is 0
// - test-skip-set skips next instruction when the bit is 1
// - literal add puts accumulator plus immediate into accumulator
// - literal logic ops store in accumulator, update only zero flag
// - literal load takes one cycle; return-with-literal loads and returns in two
// - call pushes next address, loads 12-bit target, two cycles
// - jump loads 12-bit target into the counter, two cycles, no flags
// - standby stops the core and updates the watchdog and sleep flags
// - watchdog clear pulses the watchdog and updates both flags
module mid_core #(parameter int STACK_DEPTH = 8)
(
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	output logic [mid_pkg::PCW-1:0] PROG_ADDR_O,
	input wire logic [mid_pkg::IW-1:0] PROG_DATA_I,
	output logic RPL_WE_O,
	output logic [mid_pkg::RAW-1:0] RPL_ADDR_O,
	output logic [mid_pkg::DW-1:0] RPL_DATA_O,
	output logic WDT_CLEAR_O,
	output logic STANDBY_O,
	output logic GIE_O
);
	import mid_pkg::*;
	localparam int SPW = $clog2(STACK_DEPTH);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	mid_state_t state_reg;
	mid_op_t op;
	logic [IW-1:0] instr_reg;
	logic [PCW-1:0] pc_reg;
	logic [PCW-1:0] stack_reg [STACK_DEPTH];
	logic [SPW-1:0] sp_reg;
	logic [SPW-1:0] sp_dec;
	logic [FAW-1:0] rf_addr_reg;
	logic [DW-1:0] acc_reg, fval, lit, res, opb, mask;
	logic c_reg, nib_reg, z_reg, wdx_reg, slp_reg, gie_reg, skip_reg, run_reg;
	logic c_n, nib_n, upd_z, upd_c, upd_nib, set_acc, set_f, take_skip, two_cyc;
	logic exec_go, wake_req, ahb_go, dp_valid_reg, dp_write_reg;
	logic [7:0] dp_addr_reg;
	logic [8:0] add_s, sub_s;
	logic [4:0] add_n, sub_n;
	logic [31:0] hrdata_reg;
	logic hready_reg, rpl_we_reg, wdt_clr_reg, stby_reg;
	logic [RAW-1:0] rpl_addr_reg;
	logic [DW-1:0] rpl_data_reg;

	mid_rf_if #(.AW(FAW), .DW(DW)) rf (.clk(MCLK_I), .rst_n(RST_N_I));
	mid_regfile #(.AW(FAW), .DW(DW)) u_regfile (.rf(rf.mem));

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic mid_op_t decode(input logic [IW-1:0] i);
		mid_op_t o;
		o = OP_NOP;
		case (i[13:12])
			PFX_BYTE:
			begin
				if (i == OPC_NOP) o = OP_NOP;
				else if (i == OPC_STANDBY) o = OP_STANDBY;
				else if (i == OPC_WDT_CLR) o = OP_WDT_CLR;
				else if (i == OPC_RETURN) o = OP_RETURN;
				else if (i == OPC_RETURN_INT) o = OP_RETURN_INT;
				else if (i == OPC_ZERO_ACC) o = OP_ZERO_ACC;
				else if (i[11:6] == 6'h00) o = OP_ST_RPL;
				else if (i[11:7] == HI_ST_REG) o = OP_ST_REG;
				else if (i[11:7] == HI_ZERO_REG) o = OP_ZERO_REG;
				else
				begin
					case (i[11:8])
						BY_SUB: o = OP_SUB;
						BY_DEC: o = OP_DEC;
						BY_OR: o = OP_OR;
						BY_AND: o = OP_AND;
						BY_XOR: o = OP_XOR;
						BY_ADD: o = OP_ADD;
						BY_MOVE: o = i[7] ? OP_TEST_NULL : OP_LD_REG;
						BY_INV: o = OP_INV;
						BY_INC: o = OP_INC;
						BY_DEC_SKIP: o = OP_DEC_SKIP;
						BY_ROT_R: o = OP_ROT_R;
						BY_ROT_L: o = OP_ROT_L;
						BY_SWAP: o = OP_SWAP;
						BY_INC_SKIP: o = OP_INC_SKIP;
						default: o = OP_NOP;
					endcase
				end
			end
			PFX_BIT:
			begin
				if (!i[11])
				begin
					case (i[10:9])
						BIT_CLR: o = OP_BIT_CLR;
						BIT_SET: o = OP_BIT_SET;
						BIT_SKIP_CLR: o = OP_SKIP_CLR;
						default: o = OP_SKIP_SET;
					endcase
				end
				else
				begin
					case (i[11:8])
						LIT_RETURN: o = OP_RETURN_LIT;
						LIT_LD: o = OP_LD_LIT;
						LIT_OR: o = OP_OR_LIT;
						LIT_AND: o = OP_AND_LIT;
						LIT_ADD: o = OP_ADD_LIT;
						LIT_XOR: o = OP_XOR_LIT;
						default: o = OP_NOP;
					endcase
				end
			end
			PFX_CALL: o = OP_CALL;
			default: o = OP_JUMP;
		endcase
		return o;
	endfunction

	assign op = decode(instr_reg);
	assign exec_go = (state_reg == ST_EXEC) && !skip_reg;

	// ----------------------------------------
	// arithmetic and result select
	// ----------------------------------------
	assign fval = rf.rdata;
	assign lit = instr_reg[7:0];
	assign opb = (op == OP_ADD_LIT) ? lit : fval;
	assign mask = 8'h01 << instr_reg[8:6];
	assign add_s = {1'b0, acc_reg} + {1'b0, opb};
	assign sub_s = {1'b0, fval} + {1'b0, ~acc_reg} + 9'h001;
	assign add_n = {1'b0, acc_reg[3:0]} + {1'b0, opb[3:0]};
	assign sub_n = {1'b0, fval[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
	assign two_cyc = (op == OP_CALL) || (op == OP_JUMP) || (op == OP_RETURN) ||
		(op == OP_RETURN_INT) || (op == OP_RETURN_LIT);

	always_comb
	begin
		res = fval;
		c_n = c_reg;
		nib_n = nib_reg;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_nib = 1'b0;
		set_acc = 1'b0;
		set_f = 1'b0;
		take_skip = 1'b0;
		if (instr_reg[13:12] == PFX_BYTE && instr_reg[11:8] >= BY_SUB)
		begin
			set_acc = !instr_reg[7];
			set_f = instr_reg[7];
		end
		case (op)
			OP_ADD, OP_ADD_LIT:
			begin
				res = add_s[7:0];
				c_n = add_s[8];
				nib_n = add_n[4];
				{upd_z, upd_c, upd_nib} = 3'h7;
				set_acc = set_acc || (op == OP_ADD_LIT);
			end
			OP_SUB:
			begin
				res = sub_s[7:0];
				c_n = sub_s[8];
				nib_n = sub_n[4];
				{upd_z, upd_c, upd_nib} = 3'h7;
			end
			OP_AND: {res, upd_z} = {acc_reg & fval, 1'b1};
			OP_OR: {res, upd_z} = {acc_reg | fval, 1'b1};
			OP_XOR: {res, upd_z} = {acc_reg ^ fval, 1'b1};
			OP_INV: {res, upd_z} = {~fval, 1'b1};
			OP_INC: {res, upd_z} = {fval + 8'h01, 1'b1};
			OP_DEC: {res, upd_z} = {fval - 8'h01, 1'b1};
			OP_INC_SKIP, OP_DEC_SKIP:
			begin
				res = (op == OP_INC_SKIP) ? fval + 8'h01 : fval - 8'h01;
				take_skip = (res == 8'h00);
			end
			OP_ROT_L: {c_n, res, upd_c} = {fval, c_reg, 1'b1};
			OP_ROT_R: {res, c_n, upd_c} = {c_reg, fval, 1'b1};
			OP_SWAP: res = {fval[3:0], fval[7:4]};
			OP_BIT_CLR: {res, set_f} = {fval & ~mask, 1'b1};
			OP_BIT_SET: {res, set_f} = {fval | mask, 1'b1};
			OP_SKIP_CLR: take_skip = !(|(fval & mask));
			OP_SKIP_SET: take_skip = |(fval & mask);
			OP_AND_LIT: {res, upd_z, set_acc} = {acc_reg & lit, 2'h3};
			OP_OR_LIT: {res, upd_z, set_acc} = {acc_reg | lit, 2'h3};
			OP_XOR_LIT: {res, upd_z, set_acc} = {acc_reg ^ lit, 2'h3};
			OP_LD_LIT, OP_RETURN_LIT: {res, set_acc} = {lit, 1'b1};
			OP_LD_REG: {res, set_acc} = {fval, 1'b1};
			OP_ST_REG: {res, set_f} = {acc_reg, 1'b1};
			OP_ZERO_REG: {res, set_f, upd_z} = {8'h00, 2'h3};
			OP_ZERO_ACC: {res, set_acc, upd_z} = {8'h00, 2'h3};
			OP_TEST_NULL: {set_acc, set_f, upd_z} = 3'h1;
			default: {set_acc, set_f} = 2'h0;
		endcase
	end

	assign rf.addr = rf_addr_reg;
	assign rf.we = exec_go && set_f;
	assign rf.wdata = res;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			state_reg <= ST_FETCH;
		end
		else
		begin
			case (state_reg)
				ST_FETCH: state_reg <= run_reg ? ST_LOAD : ST_FETCH;
				ST_LOAD: state_reg <= ST_READ;
				ST_READ: state_reg <= ST_EXEC;
				ST_EXEC:
				begin
					if (exec_go && op == OP_STANDBY)
						state_reg <= ST_STANDBY;
					else if (exec_go && two_cyc)
						state_reg <= ST_WAIT2;
					else
						state_reg <= ST_FETCH;
				end
				ST_WAIT2: state_reg <= ST_FETCH;
				ST_STANDBY: state_reg <= wake_req ? ST_FETCH : ST_STANDBY;
				default: state_reg <= ST_FETCH;
			endcase
		end
	end

	// fetch, program counter and skip
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			instr_reg <= INSTR_RST;
			rf_addr_reg <= '0;
			pc_reg <= PC_RST;
			skip_reg <= 1'b0;
		end
		else if (state_reg == ST_LOAD)
		begin
			instr_reg <= PROG_DATA_I;
			rf_addr_reg <= (PROG_DATA_I[13:12] == PFX_BIT) ?
				{1'b0, PROG_DATA_I[5:0]} : PROG_DATA_I[6:0];
			pc_reg <= pc_reg + 12'h001;
		end
		else if (state_reg == ST_EXEC)
		begin
			skip_reg <= exec_go && take_skip;
			if (exec_go && (op == OP_CALL || op == OP_JUMP))
				pc_reg <= instr_reg[11:0];
			else if (exec_go && (op == OP_RETURN || op == OP_RETURN_INT || op == OP_RETURN_LIT))
				pc_reg <= stack_reg[sp_dec];
		end
	end

	// return stack
	assign sp_dec = sp_reg - 1'b1;
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			sp_reg <= '0;
		end
		else if (exec_go && op == OP_CALL)
		begin
			stack_reg[sp_reg] <= pc_reg;
			sp_reg <= sp_reg + 1'b1;
		end
		else if (exec_go && (op == OP_RETURN || op == OP_RETURN_INT || op == OP_RETURN_LIT))
		begin
			sp_reg <= sp_dec;
		end
	end

	// accumulator and flags
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			acc_reg <= ACC_RST;
			{c_reg, nib_reg, z_reg, wdx_reg, slp_reg, gie_reg} <= {6{FLAG_RST}};
		end
		else if (exec_go)
		begin
			if (set_acc) acc_reg <= res;
			if (upd_z) z_reg <= (op == OP_TEST_NULL) ? (fval == 8'h00) : (res == 8'h00);
			if (upd_c) c_reg <= c_n;
			if (upd_nib) nib_reg <= nib_n;
			if (op == OP_STANDBY) {wdx_reg, slp_reg} <= 2'h1;
			if (op == OP_WDT_CLR) {wdx_reg, slp_reg} <= 2'h0;
			if (op == OP_RETURN_INT) gie_reg <= 1'b1;
		end
	end

	// side outputs
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			{rpl_we_reg, wdt_clr_reg, stby_reg} <= 3'h0;
			rpl_addr_reg <= '0;
			rpl_data_reg <= '0;
		end
		else
		begin
			rpl_we_reg <= exec_go && op == OP_ST_RPL;
			rpl_addr_reg <= instr_reg[5:0];
			rpl_data_reg <= acc_reg;
			wdt_clr_reg <= exec_go && op == OP_WDT_CLR;
			if (exec_go && op == OP_STANDBY)
				stby_reg <= 1'b1;
			else if (state_reg == ST_STANDBY && wake_req)
				stby_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign ahb_go = HSEL_I && HTRANS_I[1] && HREADY_I;
	assign wake_req = dp_valid_reg && dp_write_reg && dp_addr_reg == CTRL_OFS &&
		HWDATA_I[CTRL_WAKE_BIT];

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			{dp_valid_reg, dp_write_reg} <= 2'h0;
			dp_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
			hready_reg <= 1'b1;
			run_reg <= RUN_RST;
		end
		else
		begin
			dp_valid_reg <= ahb_go;
			dp_write_reg <= HWRITE_I;
			dp_addr_reg <= HADDR_I[7:0];
			hready_reg <= 1'b1;
			if (dp_valid_reg && dp_write_reg && dp_addr_reg == CTRL_OFS)
				run_reg <= HWDATA_I[CTRL_RUN_BIT];
			hrdata_reg <= 32'h0000_0000;
			if (ahb_go && !HWRITE_I)
			begin
				case (HADDR_I[7:0])
					CTRL_OFS: hrdata_reg[CTRL_RUN_BIT] <= run_reg;
					STATE_OFS: hrdata_reg[ST_SKIP_BIT:0] <= {skip_reg, gie_reg, stby_reg,
						slp_reg, wdx_reg, z_reg, nib_reg, c_reg, acc_reg};
					PC_OFS: hrdata_reg[PC_SP_LSB+SPW-1:0] <= {sp_reg, 4'h0, pc_reg};
					default: hrdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign HRDATA_O = hrdata_reg;
	assign HREADYOUT_O = hready_reg;
	assign HRESP_O = 1'b0;
	assign PROG_ADDR_O = pc_reg;
	assign RPL_WE_O = rpl_we_reg;
	assign RPL_ADDR_O = rpl_addr_reg;
	assign RPL_DATA_O = rpl_data_reg;
	assign WDT_CLEAR_O = wdt_clr_reg;
	assign STANDBY_O = stby_reg;
	assign GIE_O = gie_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_walk;
		state_reg == ST_LOAD ##1 state_reg == ST_READ ##1 state_reg == ST_EXEC;
	endsequence
	sequence s_two;
		state_reg == ST_WAIT2 ##1 state_reg == ST_FETCH;
	endsequence

	property p_walk;
		state_reg == ST_FETCH && run_reg |=> s_walk;
	endproperty
	a_walk: assert property (p_walk) else $error("fetch walk broken");
	property p_dest;
		exec_go && op == OP_ADD && !instr_reg[7] |-> !rf.we;
	endproperty
	a_dest: assert property (p_dest) else $error("acc destination wrote file");
	property p_logic_flags;
		exec_go && (op == OP_AND || op == OP_INC) |=> $stable({c_reg, nib_reg});
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("carry changed");
	property p_swap;
		exec_go && op == OP_SWAP |=> $stable({c_reg, nib_reg, z_reg});
	endproperty
	a_swap: assert property (p_swap) else $error("swap changed flags");
	property p_skip_zero;
		exec_go && op == OP_DEC_SKIP && fval == 8'h01 |=> skip_reg ##4 !skip_reg;
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");
	property p_bit_addr;
		state_reg == ST_EXEC && (op == OP_BIT_CLR || op == OP_BIT_SET) |-> !rf_addr_reg[6];
	endproperty
	a_bit_addr: assert property (p_bit_addr) else $error("bit op above 3Fh");
	property p_skip_clr;
		exec_go && op == OP_SKIP_CLR |=> skip_reg == !$past(|(fval & mask));
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("clear test skip wrong");
	property p_skip_set;
		exec_go && op == OP_SKIP_SET |=> skip_reg == $past(|(fval & mask));
	endproperty
	a_skip_set: assert property (p_skip_set) else $error("set test skip wrong");
	property p_jump;
		exec_go && op == OP_JUMP |=> (pc_reg == $past(instr_reg[11:0])) and s_two;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target or length");
	property p_call;
		exec_go && op == OP_CALL |=> stack_reg[sp_dec] == $past(pc_reg);
	endproperty
	a_call: assert property (p_call) else $error("call push wrong");
	property p_standby;
		exec_go && op == OP_STANDBY |=> state_reg == ST_STANDBY && STANDBY_O && slp_reg;
	endproperty
	a_standby: assert property (p_standby) else $error("standby not entered");
	property p_wdt;
		exec_go && op == OP_WDT_CLR |=> WDT_CLEAR_O && !slp_reg ##1 !WDT_CLEAR_O;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear pulse wrong");
endmodule

//--- mid_prog_mem.sv
// program memory model supplying instruction words to the decoder core
`timescale 1ns/10ps
module mid_prog_mem
(
	input wire logic clk_i,
	input wire logic [mid_pkg::PCW-1:0] addr_i,
	output logic [mid_pkg::IW-1:0] data_o
);
	import mid_pkg::*;
	logic [IW-1:0] mem [0:15];
	// ----------------------------------------
	// synchronous read, one cycle latency
	// ----------------------------------------
	always_ff @(posedge clk_i)
		data_o <= mem[addr_i[3:0]];
endmodule

//--- tb.sv
// self-checking bench for the instruction decoder core
`timescale 1ns/10ps
module tb;
	import mid_pkg::*;
	logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, rd_dp = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic hready, hresp, rpl_we, wdt_clr, stby, gie;
	logic [PCW-1:0] pa;
	logic [IW-1:0] pd;
	logic [IW-1:0] prog [16];
	logic [RAW-1:0] rpl_a;
	logic [DW-1:0] rpl_d;
	logic [13:0] rpl_seen;
	logic [63:0] e;
	logic [63:0] expq [$];
	int mismatches = 0, total_checks = 0, cycles = 0, wdt_cnt = 0, seed = 69573;
	mid_core DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.PROG_ADDR_O(pa), .PROG_DATA_I(pd), .RPL_WE_O(rpl_we), .RPL_ADDR_O(rpl_a),
		.RPL_DATA_O(rpl_d), .WDT_CLEAR_O(wdt_clr), .STANDBY_O(stby), .GIE_O(gie));
	mid_prog_mem u_mem (.clk_i(mclk), .addr_i(pa), .data_o(pd));
	// ----------------------------------------
	// clock, timeout and result monitor
	// ----------------------------------------
	initial
		forever #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (wdt_clr === 1'b1)
			wdt_cnt++;
		if (rpl_we === 1'b1)
			rpl_seen = {rpl_a, rpl_d};
		if (rd_dp === 1'b1)
		begin
			e = expq.pop_front();
			check(e[63:32], hrdata & e[31:0]);
		end
		if (cycles == 20000)
		begin
			mismatches++;
			end_sim;
		end
	end
	task automatic check(input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex)
		begin
			mismatches++;
			$display("unexpected at %0t: expected %h got %h", $time, ex, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// bus cycles and program runs
	// ----------------------------------------
	task automatic ahb(input logic wr, input logic [31:0] a, wd, ex, mk);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge mclk);
		while (hready !== 1'b1)
			@(posedge mclk);
		htrans <= 2'h0;
		hwdata <= wd;
		rd_dp <= !wr;
		if (!wr)
			expq.push_back({ex & mk, mk});
		@(posedge mclk);
		while (hready !== 1'b1)
			@(posedge mclk);
		rd_dp <= 1'b0;
		hsel <= 1'b0;
	endtask
	task automatic st(input logic [31:0] ex);
		ahb(1'b0, {24'h0, STATE_OFS}, 32'h0, ex, 32'hffff);
	endtask
	function automatic logic [31:0] sv(input logic [7:0] acc, input logic c, dc, z);
		return {21'h0, z, dc, c, acc};
	endfunction
	task automatic go;
		for (int i = 0; i < 16; i++)
			u_mem.mem[i] = prog[i];
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (70) @(posedge mclk);
		prog = '{default: OPC_NOP};
	endtask
	// ----------------------------------------
	// scenario tasks
	// ----------------------------------------
	task automatic op_case(input logic lit, input logic [3:0] op, input logic d, zt);
		logic [7:0] k1, k2, r;
		logic [6:0] f;
		logic [8:0] s;
		logic c, dc, z, sk, ad, sb;
		k1 = 8'($random(seed));
		k2 = 8'($random(seed));
		f = 7'($random(seed));
		sk = !lit && (op == BY_DEC_SKIP || op == BY_INC_SKIP);
		if (zt && sk)
			k1 = (op == BY_INC_SKIP) ? 8'hff : 8'h01;
		s = {1'b0, k1} + {1'b0, k2};
		ad = lit ? op == LIT_ADD : op == BY_ADD;
		sb = !lit && op == BY_SUB;
		if (lit)
			r = op == LIT_LD ? k2 : op == LIT_OR ? k1 | k2 : op == LIT_AND ? k1 & k2 :
				op == LIT_ADD ? s[7:0] : op == LIT_XOR ? k1 ^ k2 : k1;
		else
			case (op)
				BY_SUB: r = k1 - k2;
				BY_DEC, BY_DEC_SKIP: r = k1 - 8'h01;
				BY_OR: r = k1 | k2;
				BY_AND: r = k1 & k2;
				BY_XOR: r = k1 ^ k2;
				BY_ADD: r = s[7:0];
				BY_INV: r = ~k1;
				BY_INC, BY_INC_SKIP: r = k1 + 8'h01;
				BY_ROT_R: r = {1'b0, k1[7:1]};
				BY_ROT_L: r = {k1[6:0], 1'b0};
				BY_SWAP: r = {k1[3:0], k1[7:4]};
				default: r = k1;
			endcase
		c = (ad && s[8]) || (sb && k1 >= k2) || (!lit && op == BY_ROT_L && k1[7])
			|| (!lit && op == BY_ROT_R && k1[0]);
		dc = (ad && (s[4] ^ k1[4] ^ k2[4])) || (sb && k1[3:0] >= k2[3:0]);
		z = r == 8'h00 && (lit ? op inside {LIT_OR, LIT_AND, LIT_ADD, LIT_XOR} :
			op <= BY_ADD || op == BY_INV || op == BY_INC || (op == BY_MOVE && d));
		prog[0] = {PFX_BIT, LIT_LD, k1};
		prog[1] = {6'h00, 1'b1, f};
		prog[2] = lit ? OPC_NOP : {PFX_BIT, LIT_LD, k2};
		prog[3] = lit ? {PFX_BIT, op, k2} : {PFX_BYTE, op, d, f};
		prog[4] = (sk && !d) ? {PFX_BIT, LIT_LD, 8'ha5} : OPC_NOP;
		prog[5] = (!lit && d) ? {PFX_BYTE, BY_MOVE, 1'b0, f} : OPC_NOP;
		prog[6] = {2'h3, 12'h006};
		go;
		st(sv((sk && !d && r != 8'h00) ? 8'ha5 : r, c, dc, z));
	endtask
	task automatic bit_case(input logic [1:0] op);
		logic [7:0] k1, r;
		logic [5:0] f;
		logic [2:0] b;
		k1 = 8'($random(seed));
		f = 6'($random(seed));
		b = 3'($random(seed));
		prog[0] = {PFX_BIT, LIT_LD, k1};
		prog[1] = {7'h01, 1'b0, f};
		prog[2] = {PFX_BIT, 1'b0, op, b, f};
		prog[3] = op < 2 ? {PFX_BYTE, BY_MOVE, 2'h0, f} : {PFX_BIT, LIT_LD, 8'ha5};
		prog[4] = {2'h3, 12'h004};
		r = op == 0 ? k1 & ~(8'h01 << b) : op == 1 ? k1 | (8'h01 << b) :
			(k1[b] == op[0]) ? k1 : 8'ha5;
		go;
		st(sv(r, 1'b0, 1'b0, 1'b0));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		prog = '{default: OPC_NOP};
		go;
		ahb(1'b0, {24'h0, CTRL_OFS}, 32'h0, 32'h1, 32'h3);
		ahb(1'b1, 32'h0c, 32'hffff, 32'h0, 32'h0);
		ahb(1'b0, 32'h0c, 32'h0, 32'h0, 32'hffffffff);
		$display("test bus done");
		for (int op = 2; op < 16; op++)
			for (int n = 0; n < 4; n++)
				op_case(1'b0, 4'(op), n[0], n[1]);
		for (int op = 9; op < 16; op++)
			for (int n = 0; n < 3; n++)
				op_case(1'b1, 4'(op), 1'b0, 1'b0);
		for (int n = 0; n < 12; n++)
			bit_case(2'(n));
		$display("test operations done");
		prog[0] = {PFX_CALL, 12'h004};
		prog[1] = {PFX_CALL, 12'h006};
		prog[2] = {PFX_BIT, LIT_ADD, 8'h01};
		prog[3] = {2'h3, 12'h003};
		prog[4] = OPC_RETURN_INT;
		prog[6] = {PFX_CALL, 12'h008};
		prog[7] = OPC_RETURN;
		prog[8] = {PFX_BIT, LIT_RETURN, 8'h09};
		go;
		st(32'h400a);
		ahb(1'b1, {24'h0, CTRL_OFS}, 32'h0, 32'h0, 32'h0);
		repeat (6) @(posedge mclk);
		ahb(1'b0, {24'h0, PC_OFS}, 32'h0, 32'h3, 32'h7ffff);
		check(32'h1, {31'h0, gie});
		prog[0] = {PFX_BIT, LIT_LD, 8'h5a};
		prog[1] = 14'h0041;
		prog[2] = 14'h0100;
		prog[3] = {PFX_BIT, 4'hd, 8'hff};
		prog[4] = {7'h01, 7'h21};
		prog[5] = OPC_ZERO_ACC;
		prog[6] = {PFX_BYTE, BY_MOVE, 8'h21};
		prog[7] = 14'h002a;
		prog[8] = {2'h3, 12'h008};
		go;
		st(sv(8'h5a, 1'b0, 1'b0, 1'b1));
		check(32'h2a5a, 32'(rpl_seen));
		$display("test control done");
		prog[0] = OPC_WDT_CLR;
		prog[1] = OPC_STANDBY;
		prog[2] = {PFX_BIT, LIT_LD, 8'h33};
		prog[3] = {2'h3, 12'h003};
		wdt_cnt = 0;
		go;
		st(32'h3000);
		check(32'h1, {31'h0, stby});
		check(32'h1, 32'(wdt_cnt));
		ahb(1'b1, {24'h0, CTRL_OFS}, 32'h3, 32'h0, 32'h0);
		repeat (20) @(posedge mclk);
		st(32'h1033);
		check(32'h0, {31'h0, stby});
		$display("test standby done");
		end_sim;
	end
endmodule
